// *** srg_pkg.sv ***
// Package of constants, types and helpers for the serial rate generator block
package srg_pkg;

    // Structure of the block
    localparam int NUM_PORTS = 2;
    localparam int REG_W = 8;
    localparam int DIV_W = 16;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int PRESC_W = 6;

    // Clock of the block
    localparam int CLK_PERIOD_NS = 8;

    // Address layout: one window of 32 bytes per port
    localparam int PORT_BIT = 5;
    localparam int OFS_W = 5;
    localparam logic [1:0] ADR_TOP_ZERO = 2'h0;
    localparam logic [OFS_W-1:0] OFS_TX_CTRL = 5'h00;
    localparam logic [OFS_W-1:0] OFS_RX_CTRL = 5'h04;
    localparam logic [OFS_W-1:0] OFS_RATE_CTRL = 5'h08;
    localparam logic [OFS_W-1:0] OFS_DIV_HIGH = 5'h0C;
    localparam logic [OFS_W-1:0] OFS_DIV_LOW = 5'h10;
    localparam logic [OFS_W-1:0] OFS_STATUS = 5'h14;

    // Field positions in tx_status_control
    localparam int TX_CSRC_BIT = 7;
    localparam int TX_SYNC_BIT = 4;
    localparam int TX_HIGH_SPEED_PRESCALE_SELECT_BIT = 2;
    localparam int TX_TRMT_BIT = 1;
    // Field positions in rx_status_control
    localparam int RX_SPEN_BIT = 7;
    // Field positions in rate_control
    localparam int RATE_RCIDL_BIT = 6;
    localparam int RATE_RXDTP_BIT = 5;
    localparam int RATE_TXCKP_BIT = 4;
    localparam int RATE_WIDE_DIVISOR_SELECT_BIT = 3;
    // Field positions in the status register
    localparam int STAT_RX_LEVEL_BIT = 0;
    localparam int STAT_BIT_CLK_BIT = 1;
    localparam int STAT_RUN_BIT = 2;

    // Writable bits and reset values
    localparam logic [REG_W-1:0] TX_WMASK = 8'hFD;
    localparam logic [REG_W-1:0] RX_WMASK = 8'hF8;
    localparam logic [REG_W-1:0] RATE_WMASK = 8'hBB;
    localparam logic [REG_W-1:0] REG_RESET = 8'h00;
    localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0000_0000;

    // Prescale ratios of the rate formulas
    localparam int RATIO_SLOW = 64;
    localparam int RATIO_MID = 16;
    localparam int RATIO_FAST = 4;
    localparam logic [PRESC_W-1:0] PRESC_LAST_SLOW = PRESC_W'(RATIO_SLOW - 1);
    localparam logic [PRESC_W-1:0] PRESC_LAST_MID = PRESC_W'(RATIO_MID - 1);
    localparam logic [PRESC_W-1:0] PRESC_LAST_FAST = PRESC_W'(RATIO_FAST - 1);
    // Bit clock edges inside one synchronous period of four timer ticks
    localparam logic [PRESC_W-1:0] PRESC_HALF_FAST = PRESC_W'(RATIO_FAST / 2 - 1);

    // Register selects of the decoder
    typedef enum logic [2:0] {
        SRG_SEL_NONE = 3'b000,
        SRG_SEL_TX = 3'b001,
        SRG_SEL_RX = 3'b010,
        SRG_SEL_RATE = 3'b011,
        SRG_SEL_DIV_HIGH = 3'b100,
        SRG_SEL_DIV_LOW = 3'b101,
        SRG_SEL_STATUS = 3'b110
    } srg_sel_t;

    // Configuration carried from the register file to one generator
    typedef struct packed {
        logic enable;
        logic sync;
        logic wide;
        logic high_speed;
        logic master;
        logic clk_invert;
        logic rx_invert;
    } srg_cfg_t;

    // Divisor seen by the timer: pair in wide mode, low byte only otherwise
    function automatic logic [DIV_W-1:0] srg_eff_divisor(input logic wide,
            input logic [REG_W-1:0] high, input logic [REG_W-1:0] low);
        return wide ? {high, low} : {{(DIV_W - REG_W){1'b0}}, low};
    endfunction

    // Last prescale count for the selected mode
    function automatic logic [PRESC_W-1:0] srg_presc_last(input srg_cfg_t cfg);
        logic [PRESC_W-1:0] last;
        last = PRESC_LAST_FAST;
        if (cfg.sync) begin
            last = PRESC_LAST_FAST;
        end else if (!cfg.wide && !cfg.high_speed) begin
            last = PRESC_LAST_SLOW;
        end else if (cfg.wide && cfg.high_speed) begin
            last = PRESC_LAST_FAST;
        end else begin
            last = PRESC_LAST_MID;
        end
        return last;
    endfunction

endpackage

// *** srg_majority.sv ***
// Three-sample majority detector for one receive pin
`timescale 1ns/10ps
`default_nettype none
module srg_majority
    import srg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Sampling control
    input wire logic sample_i,
    input wire logic invert_i,
    input wire logic pin_i,
    // Decided level
    output logic level_o
);

    logic [2:0] samples_reg;
    logic level_reg;

    // Sample history, idle line is high so the history starts high
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            samples_reg <= 3'h7;
        end else if (ce_i && sample_i) begin
            samples_reg <= {samples_reg[1:0], pin_i};
        end
    end

    // Vote of the three samples, registered so the output is clean
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            level_reg <= 1'b1;
        end else if (ce_i) begin
            level_reg <= ((samples_reg[0] & samples_reg[1]) | (samples_reg[1] & samples_reg[2])
                | (samples_reg[0] & samples_reg[2])) ^ invert_i;
        end
    end

    assign level_o = level_reg;

endmodule
`default_nettype wire

// *** srg_rate_gen.sv ***
// Free-running divisor timer with mode prescaler for one serial port
`timescale 1ns/10ps
`default_nettype none
module srg_rate_gen
    import srg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Configuration
    input wire srg_cfg_t cfg_i,
    input wire logic [DIV_W-1:0] divisor_i,
    input wire logic clear_i,
    // Timing outputs
    output logic timer_tick_o,
    output logic bit_tick_o,
    output logic bit_clk_o
);

    logic [DIV_W-1:0] count_reg;
    logic [PRESC_W-1:0] presc_reg;
    logic clk_level_reg;
    logic bit_tick_reg;
    logic run;
    logic timer_wrap;
    logic presc_wrap;

    assign run = cfg_i.enable && !clear_i;
    assign timer_wrap = run && (count_reg >= divisor_i); // >= so a smaller divisor never overruns
    assign presc_wrap = timer_wrap && (presc_reg >= srg_presc_last(cfg_i));
    assign timer_tick_o = timer_wrap;

    // Timer counts 0..n, one tick every n+1 clocks; a divisor write restarts it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_reg <= {DIV_W{1'b0}};
        end else if (ce_i) begin
            if (!run || timer_wrap) begin
                count_reg <= {DIV_W{1'b0}};
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    // Prescaler gives 64, 16 or 4 timer ticks per bit
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            presc_reg <= {PRESC_W{1'b0}};
        end else if (ce_i) begin
            if (!run || presc_wrap) begin
                presc_reg <= {PRESC_W{1'b0}};
            end else if (timer_wrap) begin
                presc_reg <= presc_reg + 1'b1;
            end
        end
    end

    // Bit tick pulse and synchronous clock level, both from flip-flops
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bit_tick_reg <= 1'b0;
            clk_level_reg <= 1'b0;
        end else if (ce_i) begin
            bit_tick_reg <= presc_wrap;
            if (!run || !cfg_i.sync) begin
                clk_level_reg <= 1'b0;
            end else if (timer_wrap && (presc_wrap || presc_reg == PRESC_HALF_FAST)) begin
                clk_level_reg <= !clk_level_reg;
            end
        end
    end

    assign bit_tick_o = bit_tick_reg;
    assign bit_clk_o = clk_level_reg ^ cfg_i.clk_invert;

endmodule
`default_nettype wire

// *** srg_top.sv ***
// Two-port serial rate generator with receive majority sampling and Wishbone registers
//
// Summary of operation
// - Bit timing counts system clocks; software rewrites divisor
// - Receive pin decided by three-sample majority
// - Async 8-bit slow: clock over 64(n+1)
// - Async 16-bit slow: clock over 16(n+1)
// - Synchronous: clock over 4(n+1), prescale ignored
// - Divisor is high byte joined to low
// - Each port owns its five registers
// - Divisor byte write restarts the timer
// - Default 8-bit, high byte ignored until selected
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module srg_top
    import srg_pkg::*;
(
    // Clock, reset and clock enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [SEL_W-1:0] wb_sel_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    output logic [DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Receive pins, one per port
    input wire logic [NUM_PORTS-1:0] receive_pin_i,
    // Sampled receive level, one per port
    output logic [NUM_PORTS-1:0] rx_level_o,
    // Bit timing, one per port
    output logic [NUM_PORTS-1:0] bit_tick_o,
    output logic [NUM_PORTS-1:0] sample_tick_o,
    // Synchronous master clock pin, one per port
    output logic [NUM_PORTS-1:0] bit_clk_o,
    output logic [NUM_PORTS-1:0] bit_clk_oe_o
);

    // Register file, one entry per port
    logic [REG_W-1:0] tx_ctrl_reg [NUM_PORTS];
    logic [REG_W-1:0] rx_ctrl_reg [NUM_PORTS];
    logic [REG_W-1:0] rate_ctrl_reg [NUM_PORTS];
    logic [REG_W-1:0] div_high_reg [NUM_PORTS];
    logic [REG_W-1:0] div_low_reg [NUM_PORTS];

    // Bus slave state
    logic ack_reg;
    logic [DAT_W-1:0] rdata_reg;
    logic [DAT_W-1:0] rdata_next;
    logic bus_req;
    logic wr_en;
    logic [NUM_PORTS-1:0] port_hit;
    srg_sel_t sel_dec;

    // Per-port wiring between registers and generators
    srg_cfg_t cfg [NUM_PORTS];
    logic [DIV_W-1:0] divisor [NUM_PORTS];
    logic [NUM_PORTS-1:0] div_write;
    logic [NUM_PORTS-1:0] timer_tick;
    logic [NUM_PORTS-1:0] bit_clk;
    logic [NUM_PORTS-1:0] rx_level;

    // Register select from the offset inside one port window
    function automatic srg_sel_t decode_sel(input logic [ADR_W-1:0] adr);
        srg_sel_t sel;
        logic [OFS_W-1:0] ofs;
        sel = SRG_SEL_NONE;
        ofs = adr[OFS_W-1:0];
        if (adr[ADR_W-1:PORT_BIT+1] != ADR_TOP_ZERO) begin
            sel = SRG_SEL_NONE;
        end else if (ofs == OFS_TX_CTRL) begin
            sel = SRG_SEL_TX;
        end else if (ofs == OFS_RX_CTRL) begin
            sel = SRG_SEL_RX;
        end else if (ofs == OFS_RATE_CTRL) begin
            sel = SRG_SEL_RATE;
        end else if (ofs == OFS_DIV_HIGH) begin
            sel = SRG_SEL_DIV_HIGH;
        end else if (ofs == OFS_DIV_LOW) begin
            sel = SRG_SEL_DIV_LOW;
        end else if (ofs == OFS_STATUS) begin
            sel = SRG_SEL_STATUS;
        end else begin
            sel = SRG_SEL_NONE;
        end
        return sel;
    endfunction

    // Masked write: only the writable bits of a register take the bus data
    function automatic logic [REG_W-1:0] merge_write(input logic [REG_W-1:0] old,
            input logic [REG_W-1:0] data, input logic [REG_W-1:0] mask);
        return (old & ~mask) | (data & mask);
    endfunction

    // A request is taken once; ack drops in the cycle after it was given
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign sel_dec = decode_sel(wb_adr_i);
    // Writes need byte lane 0, where all eight-bit registers sit
    assign wr_en = ce_i && bus_req && wb_we_i && wb_sel_i[0];

    // One-hot port select from the port bit of the address
    always_comb begin
        port_hit = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            port_hit[p] = (wb_adr_i[PORT_BIT] == p[0]);
        end
    end

    // Acknowledge every access, mapped or not, one cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_reg <= 1'b0;
        end else if (ce_i) begin
            ack_reg <= bus_req;
        end
    end

    // Transmit control, one register per port
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                tx_ctrl_reg[p] <= REG_RESET;
            end
        end else if (wr_en && sel_dec == SRG_SEL_TX) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (port_hit[p]) begin
                    tx_ctrl_reg[p] <= merge_write(tx_ctrl_reg[p], wb_dat_i[REG_W-1:0],
                        TX_WMASK);
                end
            end
        end
    end

    // Receive control, one register per port
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                rx_ctrl_reg[p] <= REG_RESET;
            end
        end else if (wr_en && sel_dec == SRG_SEL_RX) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (port_hit[p]) begin
                    rx_ctrl_reg[p] <= merge_write(rx_ctrl_reg[p], wb_dat_i[REG_W-1:0],
                        RX_WMASK);
                end
            end
        end
    end

    // Rate control, one register per port; wide divisor starts cleared
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                rate_ctrl_reg[p] <= REG_RESET;
            end
        end else if (wr_en && sel_dec == SRG_SEL_RATE) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (port_hit[p]) begin
                    rate_ctrl_reg[p] <= merge_write(rate_ctrl_reg[p], wb_dat_i[REG_W-1:0],
                        RATE_WMASK);
                end
            end
        end
    end

    // Divisor high bytes; stored even in 8-bit mode so software can preload it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                div_high_reg[p] <= REG_RESET;
            end
        end else if (wr_en && sel_dec == SRG_SEL_DIV_HIGH) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (port_hit[p]) begin
                    div_high_reg[p] <= wb_dat_i[REG_W-1:0];
                end
            end
        end
    end

    // Divisor low bytes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                div_low_reg[p] <= REG_RESET;
            end
        end else if (wr_en && sel_dec == SRG_SEL_DIV_LOW) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (port_hit[p]) begin
                    div_low_reg[p] <= wb_dat_i[REG_W-1:0];
                end
            end
        end
    end

    // Divisor write strobe per port restarts that port's timer
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            div_write[p] = wr_en && port_hit[p]
                && (sel_dec == SRG_SEL_DIV_HIGH || sel_dec == SRG_SEL_DIV_LOW);
        end
    end

    // Read mux; read-only control bits show fixed idle values since no framer is attached, status bits are live
    always_comb begin
        rdata_next = DAT_ZERO;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (port_hit[p]) begin
                if (sel_dec == SRG_SEL_TX) begin
                    rdata_next[REG_W-1:0] = tx_ctrl_reg[p];
                    rdata_next[TX_TRMT_BIT] = 1'b1;
                end else if (sel_dec == SRG_SEL_RX) begin
                    rdata_next[REG_W-1:0] = rx_ctrl_reg[p];
                end else if (sel_dec == SRG_SEL_RATE) begin
                    rdata_next[REG_W-1:0] = rate_ctrl_reg[p];
                    rdata_next[RATE_RCIDL_BIT] = 1'b1;
                end else if (sel_dec == SRG_SEL_DIV_HIGH) begin
                    rdata_next[REG_W-1:0] = div_high_reg[p];
                end else if (sel_dec == SRG_SEL_DIV_LOW) begin
                    rdata_next[REG_W-1:0] = div_low_reg[p];
                end else if (sel_dec == SRG_SEL_STATUS) begin
                    rdata_next[STAT_RX_LEVEL_BIT] = rx_level[p];
                    rdata_next[STAT_BIT_CLK_BIT] = bit_clk[p];
                    rdata_next[STAT_RUN_BIT] = cfg[p].enable;
                end
            end
        end
    end

    // Read data held in a register, loaded with the ack
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= DAT_ZERO;
        end else if (ce_i && bus_req && !wb_we_i) begin
            rdata_reg <= rdata_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Generators and samplers, one pair per port
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        // Mode bits gathered from the three control registers
        assign cfg[g].enable = rx_ctrl_reg[g][RX_SPEN_BIT];
        assign cfg[g].sync = tx_ctrl_reg[g][TX_SYNC_BIT];
        assign cfg[g].wide = rate_ctrl_reg[g][RATE_WIDE_DIVISOR_SELECT_BIT];
        assign cfg[g].high_speed = tx_ctrl_reg[g][TX_HIGH_SPEED_PRESCALE_SELECT_BIT];
        assign cfg[g].master = tx_ctrl_reg[g][TX_CSRC_BIT];
        assign cfg[g].clk_invert = rate_ctrl_reg[g][RATE_TXCKP_BIT];
        assign cfg[g].rx_invert = rate_ctrl_reg[g][RATE_RXDTP_BIT];

        // High byte and low byte form one unsigned divisor in wide mode, low byte alone in 8-bit mode
        assign divisor[g] = srg_eff_divisor(cfg[g].wide, div_high_reg[g],
            div_low_reg[g]);

        srg_rate_gen u_rate_gen (
            .clk_i(clk_i),
            .reset_n_i(reset_n_i),
            .ce_i(ce_i),
            .cfg_i(cfg[g]),
            .divisor_i(divisor[g]),
            .clear_i(div_write[g]),
            .timer_tick_o(timer_tick[g]),
            .bit_tick_o(bit_tick_o[g]),
            .bit_clk_o(bit_clk[g])
        );

        // Three samples on consecutive timer ticks
        srg_majority u_majority (
            .clk_i(clk_i),
            .reset_n_i(reset_n_i),
            .ce_i(ce_i),
            .sample_i(timer_tick[g]),
            .invert_i(cfg[g].rx_invert),
            .pin_i(receive_pin_i[g]),
            .level_o(rx_level[g])
        );
    end

    // Timer ticks are combinational, registered here for a clean output
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sample_tick_o <= '0;
        end else if (ce_i) begin
            sample_tick_o <= timer_tick;
        end
    end

    // Clock pin driven only as synchronous master of an enabled port
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            bit_clk_oe_o[p] = cfg[p].enable && cfg[p].sync && cfg[p].master;
            bit_clk_o[p] = bit_clk[p];
        end
    end

    assign rx_level_o = rx_level;

endmodule
`default_nettype wire

// *** srg_checker_assertions.sv ***
// Port-level checks for the two-port serial rate generator
`timescale 1ns/10ps
`default_nettype none
module srg_checker
    import srg_pkg::*;
(
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Per-port outputs
    input wire logic [NUM_PORTS-1:0] rx_level_o,
    input wire logic [NUM_PORTS-1:0] bit_tick_o,
    input wire logic [NUM_PORTS-1:0] sample_tick_o,
    input wire logic [NUM_PORTS-1:0] bit_clk_o,
    input wire logic [NUM_PORTS-1:0] bit_clk_oe_o
);
    // Everything here runs on the one system clock
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // Bus answer one cycle after the request, one cycle long
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper lanes not zero");
    // Shortest bit period is four timer ticks
    a_tick0_gap: assert property (bit_tick_o[0] |=> !bit_tick_o[0] [*3])
        else $error("port 0 bit ticks too close");
    a_tick1_gap: assert property (bit_tick_o[1] |=> !bit_tick_o[1] [*3])
        else $error("port 1 bit ticks too close");
    // Master clock half period is at least two timer ticks
    a_clk0_half: assert property (bit_clk_oe_o[0] && $changed(bit_clk_o[0])
        |=> $stable(bit_clk_o[0]))
        else $error("port 0 bit clock half period too short");
    // Voted level may only move right around a sampling tick
    a_level0_vote: assert property ($changed(rx_level_o[0]) |-> sample_tick_o[0]
        || $past(sample_tick_o[0]) || $past(sample_tick_o[0], 2))
        else $error("port 0 level changed without a sample");
    a_level1_vote: assert property ($changed(rx_level_o[1]) |-> sample_tick_o[1]
        || $past(sample_tick_o[1]) || $past(sample_tick_o[1], 2))
        else $error("port 1 level changed without a sample");
endmodule

bind srg_top srg_checker u_chk (.clk_i, .reset_n_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .rx_level_o, .bit_tick_o, .sample_tick_o, .bit_clk_o, .bit_clk_oe_o);
`default_nettype wire

// *** srg_far_end.sv ***
// Remote serial sender model driving both receive lines
`timescale 1ns/10ps
`default_nettype none
module srg_far_end
    import srg_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Receive lines toward the block
    output logic [NUM_PORTS-1:0] line_o
);
    // Lines rest at mark level, like an idle sender
    initial begin
        line_o = '1;
    end

    // Hold one line at a level for some clocks, then idle
    task automatic pulse(input int p, input logic lvl, input int cyc);
        @(posedge clk_i);
        line_o[p] <= lvl;
        repeat (cyc) @(posedge clk_i);
        line_o[p] <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** tb_srg_top.sv ***
// Self-checking bench for the two-port serial rate generator
`timescale 1ns/10ps
`default_nettype none
module tb_srg_top
    import srg_pkg::*;
();
    logic clk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [ADR_W-1:0] wb_adr_i;
    logic [SEL_W-1:0] wb_sel_i;
    logic [DAT_W-1:0] wb_dat_i, wb_dat_o;
    logic [NUM_PORTS-1:0] receive_pin_i, rx_level_o, bit_tick_o, sample_tick_o;
    logic [NUM_PORTS-1:0] bit_clk_o, bit_clk_oe_o;
    logic [7:0] q;
    int errors, check_count, per, m, p, n, hi, lo;

    // Bit timing counts these clocks, 8 ns each
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Block under test, clock enable left running
    srg_top uut (.clk_i, .reset_n_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .receive_pin_i, .rx_level_o, .bit_tick_o,
        .sample_tick_o, .bit_clk_o, .bit_clk_oe_o);
    srg_far_end far (.clk_i(clk_i), .line_o(receive_pin_i));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic hang();
        errors++;
        $display("Error at %0t: wait ran out", $time);
        give_verdict();
    endtask

    // One classic cycle; request held until ack is seen at a rising edge
    task automatic bus(input logic w, input int pt, input logic [4:0] ofs, input logic [7:0] d,
            input logic [3:0] s);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {2'h0, pt[0], ofs};
        wb_dat_i <= {24'h000000, d};
        wb_sel_i <= s;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 50);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (i >= 50) hang();
    endtask

    // Port held off while set up, then started from a clean count
    task automatic setup(input int pt, input logic [7:0] tx, input logic [7:0] rt,
            input logic [7:0] h, input logic [7:0] l);
        bus(1'b1, pt, OFS_RX_CTRL, 8'h00, 4'hF);
        bus(1'b1, pt, OFS_TX_CTRL, tx, 4'hF);
        bus(1'b1, pt, OFS_RATE_CTRL, rt, 4'hF);
        bus(1'b1, pt, OFS_DIV_HIGH, h, 4'hF);
        bus(1'b1, pt, OFS_DIV_LOW, l, 4'hF);
        bus(1'b1, pt, OFS_RX_CTRL, 8'h80, 4'hF);
    endtask

    // Clocks between two successive bit ticks of one port
    task automatic meas(input int pt, output int cnt);
        int i;
        i = 0;
        while (bit_tick_o[pt] !== 1'b1 && i < 20000) begin
            @(posedge clk_i);
            i++;
        end
        cnt = 0;
        do begin
            @(posedge clk_i);
            cnt++;
        end while (bit_tick_o[pt] !== 1'b1 && cnt < 20000);
        if (i >= 20000 || cnt >= 20000) hang();
    endtask

    // Mode 0 slow 8-bit, 1 fast 8-bit, 2 slow wide, 3 fast wide, 4 synchronous
    function automatic int exp_per(input int md, input int h, input int l);
        int r;
        r = (md >= 3) ? 4 : ((md == 0) ? 64 : 16);
        return r * (((md == 2 || md == 3) ? h * 256 + l : l) + 1);
    endfunction

    // Software rounding of the slow 8-bit divisor at this clock
    function automatic int div_for(input real rate);
        return $rtoi(125.0e6 / rate / 64.0 - 0.5);
    endfunction

    initial begin
        void'($urandom(6365));
        errors = 0;
        check_count = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        reset_n_i = 1'b0;
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        // Reset values, unmapped place, disabled lane, port separation
        bus(1'b0, 0, OFS_TX_CTRL, 8'h00, 4'hF);
        check(16'(q), 16'h0002);
        bus(1'b0, 0, OFS_RATE_CTRL, 8'h00, 4'hF);
        check(16'(q), 16'h0040);
        bus(1'b0, 0, OFS_STATUS, 8'h00, 4'hF);
        check(16'(q), 16'h0001);
        bus(1'b0, 0, 5'h18, 8'h00, 4'hF);
        check(16'(q), 16'h0000);
        bus(1'b1, 1, OFS_DIV_LOW, 8'h5A, 4'h0);
        bus(1'b1, 1, OFS_DIV_HIGH, 8'hA5, 4'hF);
        bus(1'b0, 1, OFS_DIV_LOW, 8'h00, 4'hF);
        check(16'(q), 16'h0000);
        bus(1'b0, 0, OFS_DIV_HIGH, 8'h00, 4'hF);
        check(16'(q), 16'h0000);
        bus(1'b0, 1, OFS_DIV_HIGH, 8'h00, 4'hF);
        check(16'(q), 16'h00A5);
        // Every rate mode with random divisors, ports taken in turn
        for (m = 0; m < 5; m++) begin
            p = m % 2;
            hi = (m == 2 || m == 3) ? $urandom_range(2, 1) : $urandom_range(255, 1);
            lo = (m == 4) ? $urandom_range(7, 2) : $urandom_range(7, 0);
            setup(p, {m == 4, 2'h0, m == 4, 1'b0, m[0] || m == 4, 2'h0}, {4'h0, m[1], 3'h0},
                hi[7:0], lo[7:0]);
            meas(p, per);
            check(16'(per), 16'(exp_per(m, hi, lo)));
            check(16'({bit_clk_oe_o[p], bit_clk_o[p]}), 16'({m == 4, 1'b0}));
        end
        // Rewriting the divisor mid-period restarts the count
        n = div_for(488281.25);
        setup(0, 8'h00, 8'h00, 8'h00, n[7:0]);
        meas(0, per);
        check(16'(per), 16'(64 * (n + 1)));
        repeat (100) @(posedge clk_i);
        bus(1'b1, 0, OFS_DIV_LOW, n[7:0], 4'hF);
        per = 0;
        do begin
            @(posedge clk_i);
            per++;
        end while (bit_tick_o[0] !== 1'b1 && per < 1000);
        check(16'(per), 16'(64 * (n + 1)));
        // Timer ticks every clock: a lone low sample is outvoted, a long one is not
        for (p = 0; p < 2; p++) begin
            setup(p, 8'h00, 8'h00, 8'h00, 8'h00);
            far.pulse(p, 1'b0, 1);
            repeat (10) @(posedge clk_i);
            check(16'(rx_level_o[p]), 16'h0001);
            far.pulse(p, 1'b0, 8);
            check(16'(rx_level_o[p]), 16'h0000);
            repeat (10) @(posedge clk_i);
            bus(1'b0, p, OFS_STATUS, 8'h00, 4'hF);
            check(16'(q), 16'h0005);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
